// ### rtl/capture_buffer.sv
// Operation
// RULE1: pattern on port A, both if dual
// RULE2: pattern mode replaces samples and range output
// RULE3: pattern range output high until empty
// RULE4: single port repeats eight-word sequence, B floats
// RULE5: dual port pairs B/A words per step
// RULE6: each word comes with strobe transition
// RULE7: depth select gives 512 to 4096 bytes
// RULE8: read only after full, never concurrent
// RULE9: empty after last word, no re-read
// RULE10: capture only from empty; start clears empty
// RULE11: read only while full, read-clock paced
// RULE12: synchronised read request clears full flag
// RULE13: buffer reset clears full, sets empty, aborts
// RULE14: write each clock while write enable held
// RULE15: without stop-on-full pointer wraps, overwrites
// RULE16: stop-on-full halts writing when full
// RULE17: free read clock, request synced to it
// RULE18: dual enable selects one or two ports
// RULE19: dual readout sends B first, then A
// RULE20: controller never asserts both enables together
// RULE21: write enable wins over read request; code freezes the buffer instead (RULE22)
// RULE22: both enables freeze until buffer reset
// RULE23: first word on third read-clock edge
// RULE24: capture start output is resynced write enable
// RULE25: normal range flag sticky until empty; buffer reset keeps it until next capture
// RULE26: power-up leaves buffer empty and idle
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module capture_buffer
	import capture_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  sample_data,
	input  wire logic        sample_out_of_range,
	input  wire logic        capture_write_enable,
	input  wire logic        read_request,
	input  wire logic        buffer_reset,
	input  wire logic        read_clk,
	output logic      [7:0]  port_a_bus,
	output logic             port_a_oe_n,
	output logic      [7:0]  port_b_bus,
	output logic             port_b_oe_n,
	output logic             data_ready_strobe,
	output logic             full_flag,
	output logic             empty_flag,
	output logic             out_of_range,
	output logic             capture_start_sync
);
	logic [SYNC_N-1:0] pins;
	logic [SYNC_N-1:0] synced;
	ctrl_t             ctrl;
	buf_state_t        state;
	logic [7:0]        mem [MEM_WORDS];
	logic [PTR_W-1:0]  wptr;
	logic [PTR_W-1:0]  rptr;
	logic [CNT_W-1:0]  cap_count;
	logic [CNT_W-1:0]  rd_count;
	logic [2:0]        pat_idx;
	logic [1:0]        lead;
	logic              rclk_prev;
	logic              frozen;

	assign pins[SYNC_WEN]   = capture_write_enable;
	assign pins[SYNC_REN]   = read_request;
	assign pins[SYNC_RESET] = buffer_reset;
	assign pins[SYNC_RCLK]  = read_clk;

	// Every pin, read clock included, is sampled by pclk
	generate
		for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
			pin_sync u_sync (
				.pclk   (pclk),
				.presetn(presetn),
				.pin    (pins[i]),
				.level  (synced[i])
			);
		end
	endgenerate

	// Decoded pin levels and read clock edge
	wire wen_level  = synced[SYNC_WEN];
	wire ren_level  = synced[SYNC_REN];
	wire rst_level  = synced[SYNC_RESET];
	wire rclk_level = synced[SYNC_RCLK];
	wire rclk_rise  = rclk_level & ~rclk_prev;
	wire both_on    = wen_level & ren_level;                        // see RULE22

	// Configured depth and pointer mask
	wire [CNT_W-1:0] depth     = DEPTH_MIN << ctrl.buffer_depth_select; // see RULE7
	wire [CNT_W-1:0] depth_m1  = depth - ONE_WORD;
	wire [PTR_W-1:0] ptr_mask  = depth_m1[PTR_W-1:0];

	// Write side decode
	wire write_hold = ctrl.stop_on_full & full_flag;                  // see RULE16
	wire do_write   = (state == ST_CAPTURE) & wen_level & ~write_hold // see RULE14
		& ~both_on & ~rst_level;
	wire [PTR_W-1:0] wptr_next = (wptr + 12'h001) & ptr_mask;         // see RULE15
	wire [CNT_W-1:0] cap_next  = cap_count + ONE_WORD;

	// Read side decode; dual steps take two bytes
	wire             dual      = ctrl.dual_port_enable;                // see RULE18
	wire             pattern   = ctrl.pattern_mode_enable;
	wire [CNT_W-1:0] step_size = dual ? TWO_WORDS : ONE_WORD;
	wire [CNT_W-1:0] rd_next   = rd_count + step_size;
	wire [PTR_W-1:0] rptr_p1   = (rptr + 12'h001) & ptr_mask;
	wire [PTR_W-1:0] rptr_step = dual ? ((rptr + 12'h002) & ptr_mask) : rptr_p1;
	wire [2:0]       pat_p1    = pat_idx + 3'h1;
	wire [2:0]       pat_step  = dual ? (pat_idx + 3'h2) : pat_p1;
	wire             out_step  = (state == ST_READ) & rclk_rise & ren_level
		& (lead == LEAD_LAST) & ~both_on & ~rst_level;
	wire             last_step = rd_next >= depth;                     // see RULE9

	// Word sources: buffer contents or pattern generator
	wire [7:0] mem_first  = mem[rptr];
	wire [7:0] mem_second = mem[rptr_p1];
	wire [7:0] pat_first  = PATTERN_SEQ[pat_idx];                       // see RULE4
	wire [7:0] pat_second = PATTERN_SEQ[pat_p1];                        // see RULE5
	wire [7:0] word_first  = pattern ? pat_first : mem_first;           // see RULE2
	wire [7:0] word_second = pattern ? pat_second : mem_second;

	// APB decode; zero wait states, errors on unmapped addresses
	wire     setup_phase = psel & ~penable & ~pready;
	wire     hit_ctrl    = (paddr == CTRL_ADDR);
	wire     hit_status  = (paddr == STATUS_ADDR);
	wire     access_done = psel & penable & pready;
	wire     ctrl_write  = access_done & pwrite & hit_ctrl & ~pslverr;
	status_t status;
	assign status = '{frozen: frozen, read_active: state == ST_READ,
		capture_active: state == ST_CAPTURE, out_of_range: out_of_range,
		full_flag: full_flag, empty_flag: empty_flag};
	wire [31:0] read_word = hit_ctrl ? {16'h0000, ctrl} :
		hit_status ? {26'h0000000, status} : 32'h00000000;

	// Bus slave; data and ready registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~hit_ctrl & ~(hit_status & ~pwrite);
			prdata  <= setup_phase & ~pwrite ? read_word : 32'h00000000;
		end
	end

	// Control register; steers depth, stop, ports and pattern
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (ctrl_write) begin
			ctrl <= pwdata[15:0];
		end
	end

	// Sample storage, no reset needed
	always_ff @(posedge pclk) begin
		if (do_write) begin
			mem[wptr] <= sample_data;                                    // see RULE14
		end
	end

	// Capture start indication and read clock history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_start_sync <= 1'b0;
			rclk_prev          <= 1'b0;
		end else begin
			capture_start_sync <= wen_level;                              // see RULE24
			rclk_prev          <= rclk_level;
		end
	end

	// Buffer sequencer. A lone read request with an unfinished
	// capture is ignored; a partial read needs a buffer reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state             <= ST_IDLE;                               // see RULE26
			empty_flag        <= 1'b1;
			full_flag         <= 1'b0;
			out_of_range      <= 1'b0;
			frozen            <= 1'b0;
			wptr              <= 12'h000;
			rptr              <= 12'h000;
			cap_count         <= 13'h0000;
			rd_count          <= 13'h0000;
			pat_idx           <= 3'h0;
			lead              <= 2'h0;
			port_a_bus        <= 8'h00;
			port_b_bus        <= 8'h00;
			port_a_oe_n       <= 1'b0;
			port_b_oe_n       <= 1'b1;
			data_ready_strobe <= 1'b0;
		end else begin
			port_b_oe_n <= ~dual;                                          // see RULE1
			if (rst_level) begin
				state      <= ST_IDLE;                                   // see RULE13
				empty_flag <= 1'b1;
				full_flag  <= 1'b0;
				frozen     <= 1'b0;
				wptr       <= 12'h000;
				cap_count  <= 13'h0000;
			end else if (both_on && state != ST_FROZEN) begin
				state  <= ST_FROZEN;                                      // see RULE21
				frozen <= 1'b1;                                           // see RULE22
			end else begin
				case (state)
					ST_IDLE: begin
						if (wen_level && empty_flag) begin
							state        <= ST_CAPTURE;                      // see RULE10
							empty_flag   <= 1'b0;
							out_of_range <= 1'b0;
							wptr         <= 12'h000;
							cap_count    <= 13'h0000;
						end
					end
					ST_CAPTURE: begin
						if (do_write) begin
							wptr <= wptr_next;
							if (sample_out_of_range && !pattern) begin
								out_of_range <= 1'b1;                        // see RULE25
							end
							if (cap_count < depth) begin
								cap_count <= cap_next;
							end
							if (cap_next >= depth) begin
								full_flag <= 1'b1;                           // see RULE8
							end
						end
						if (!wen_level && full_flag) begin
							state <= ST_FULL;
						end
					end
					ST_FULL: begin
						if (rclk_rise && ren_level && full_flag) begin
							state     <= ST_READ;                            // see RULE11
							full_flag <= 1'b0;                               // see RULE12
							rptr      <= wptr;                               // see RULE15
							rd_count  <= 13'h0000;
							pat_idx   <= 3'h0;
							lead      <= LEAD_FIRST;                         // see RULE17
						end
					end
					ST_READ: begin
						if (rclk_rise && ren_level && lead != LEAD_LAST) begin
							lead <= lead + 2'h1;                             // see RULE23
						end
						if (out_step) begin
							data_ready_strobe <= ~data_ready_strobe;         // see RULE6
							if (dual) begin
								port_b_bus <= word_first;                    // see RULE19
								port_a_bus <= word_second;
							end else begin
								port_a_bus <= word_first;
							end
							rptr     <= rptr_step;
							pat_idx  <= pat_step;
							rd_count <= rd_next;
							if (pattern) begin
								out_of_range <= ~last_step;                  // see RULE3
							end
							if (last_step) begin
								state        <= ST_IDLE;
								empty_flag   <= 1'b1;                        // see RULE9
								out_of_range <= 1'b0;                        // see RULE25
							end
						end
					end
					ST_FROZEN: begin
						state <= ST_FROZEN;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule : capture_buffer

// ### rtl/capture_pkg.sv
package capture_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  CTRL_INDEX   = 8'h0f;
	localparam logic [7:0]  STATUS_INDEX = 8'h10;
	localparam logic [11:0] CTRL_ADDR    = {2'h0, CTRL_INDEX, 2'h0};
	localparam logic [11:0] STATUS_ADDR  = {2'h0, STATUS_INDEX, 2'h0};

	// Control word layout, bit 15 down to bit 0
	typedef struct packed {
		logic [1:0]  buffer_depth_select;
		logic        stop_on_full;
		logic        dual_port_enable;
		logic        pattern_mode_enable;
		logic [10:0] fill;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{buffer_depth_select: 2'h3, stop_on_full: 1'h1,
		dual_port_enable: 1'h0, pattern_mode_enable: 1'h0, fill: 11'h7ff};

	// Status word layout, bit 5 down to bit 0
	typedef struct packed {
		logic frozen;
		logic read_active;
		logic capture_active;
		logic out_of_range;
		logic full_flag;
		logic empty_flag;
	} status_t;

	// Buffer geometry
	localparam int          PTR_W     = 12;
	localparam int          CNT_W     = 13;
	localparam int          MEM_WORDS = 4096;
	localparam logic [12:0] DEPTH_MIN = 13'h200;
	localparam logic [12:0] ONE_WORD  = 13'h001;
	localparam logic [12:0] TWO_WORDS = 13'h002;

	// Read clock edges spent before the first word appears
	localparam logic [1:0] LEAD_FIRST = 2'h1;
	localparam logic [1:0] LEAD_LAST  = 2'h2;

	// Test pattern sequence
	localparam logic [0:7][7:0] PATTERN_SEQ = {8'h01, 8'h02, 8'h03, 8'h04,
		8'hfe, 8'hfd, 8'hfc, 8'hfb};

	// Synchronised pin inputs
	localparam int SYNC_N     = 4;
	localparam int SYNC_WEN   = 0;
	localparam int SYNC_REN   = 1;
	localparam int SYNC_RESET = 2;
	localparam int SYNC_RCLK  = 3;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_CAPTURE = 5'b00010,
		ST_FULL    = 5'b00100,
		ST_READ    = 5'b01000,
		ST_FROZEN  = 5'b10000
	} buf_state_t;

endpackage : capture_pkg

// ### rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      level
);
	logic stage1;
	logic stage2;
	logic stage3;

	// Three stage flops and a level flop; level moves only once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level  <= 1'b0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level <= stage3;
			end
		end
	end

endmodule : pin_sync

// ### sim/reader_model.sv
`timescale 1ns/10ps
module reader_model (
	input	wire logic	go,
	input	wire logic	wen,
	input	wire logic	abuse,
	output	logic		read_clk,
	output	logic		read_request
);
	// Free-running read clock, kept up between frames too
	initial begin
		read_clk = 1'b0;
		forever #80 read_clk = ~read_clk;
	end
	// Request held off during capture unless told to misbehave
	assign read_request = go && (!wen || abuse);
endmodule : reader_model

// ### sim/capture_buffer_chk.sv
`timescale 1ns/10ps
module capture_buffer_chk (
	input	wire logic		pclk,
	input	wire logic		presetn,
	input	wire logic		capture_write_enable,
	input	wire logic		read_request,
	input	wire logic		buffer_reset,
	input	wire logic [7:0]	port_a_bus,
	input	wire logic		port_a_oe_n,
	input	wire logic [7:0]	port_b_bus,
	input	wire logic		port_b_oe_n,
	input	wire logic		data_ready_strobe,
	input	wire logic		full_flag,
	input	wire logic		empty_flag,
	input	wire logic		out_of_range,
	input	wire logic		capture_start_sync
);
	// Single domain, pin inputs seen through their sync delay
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_excl; !(full_flag && empty_flag); endproperty
	a_excl: assert property (p_excl) else $error("full and empty both high");
	property p_word; $changed(port_a_bus) |-> $changed(data_ready_strobe); endproperty
	a_word: assert property (p_word) else $error("word without strobe");
	property p_quiet; empty_flag && $past(empty_flag) |-> $stable(data_ready_strobe); endproperty
	a_quiet: assert property (p_quiet) else $error("read while empty");
	property p_efall; $fell(empty_flag) |-> $past(capture_write_enable, 3); endproperty
	a_efall: assert property (p_efall) else $error("empty cleared unasked");
	property p_ffall;
		$fell(full_flag) |-> $past(read_request, 3) || $past(buffer_reset, 3);
	endproperty
	a_ffall: assert property (p_ffall) else $error("full cleared unasked");
	property p_start; $rose(capture_start_sync) |-> $past(capture_write_enable, 2); endproperty
	a_start: assert property (p_start) else $error("start sync without enable");
	property p_breset; buffer_reset [*8] |=> empty_flag && !full_flag; endproperty
	a_breset: assert property (p_breset) else $error("buffer reset ignored");
	// A finished readout or the start of a capture clears the range flag; a buffer reset keeps it
	property p_orclr;
		$rose(empty_flag) && $changed(data_ready_strobe) |-> !out_of_range;
	endproperty
	a_orclr: assert property (p_orclr) else $error("range flag kept at empty");
	property p_bfloat;
		$changed(port_b_bus) |-> !port_b_oe_n && $changed(data_ready_strobe);
	endproperty
	a_bfloat: assert property (p_bfloat) else $error("port B moved while floating");
	property p_adrv; !port_a_oe_n; endproperty
	a_adrv: assert property (p_adrv) else $error("port A not driven");
	c_full: cover property ($rose(full_flag));
	c_empty: cover property ($rose(empty_flag));
	c_breset: cover property (buffer_reset [*8]);
endmodule : capture_buffer_chk

bind capture_buffer capture_buffer_chk capture_buffer_chk_inst (.pclk, .presetn,
	.capture_write_enable, .read_request, .buffer_reset, .port_a_bus, .port_a_oe_n,
	.port_b_bus, .port_b_oe_n, .data_ready_strobe, .full_flag, .empty_flag, .out_of_range,
	.capture_start_sync);

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import capture_pkg::*;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [7:0]	sample_data, port_a_bus, port_b_bus, prev;
	logic		sor, wen, go, abuse, buffer_reset, read_clk, read_request, last;
	logic		port_a_oe_n, port_b_oe_n, data_ready_strobe;
	logic		full_flag, empty_flag, out_of_range, capture_start_sync;
	int		n_errors, checks_done, m;

	capture_buffer capture_buffer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sample_data, .sample_out_of_range(sor),
		.capture_write_enable(wen), .read_request, .buffer_reset, .read_clk, .port_a_bus,
		.port_a_oe_n, .port_b_bus, .port_b_oe_n, .data_ready_strobe, .full_flag,
		.empty_flag, .out_of_range, .capture_start_sync);
	reader_model reader_model_inst (.go, .wen, .abuse, .read_clk, .read_request);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Counting samples make stored order visible; one range hit per 256
	always @(posedge pclk) begin
		sample_data <= sample_data + 8'h01;
		sor <= (sample_data == 8'h40);
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// One APB transfer; request held until pready is seen at a rising edge.
	// Flop outputs read just after the edge still show what that edge samples.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge pclk);
		end
		if (k == 20) begin
			n_errors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic capture(input int depth);
		int k, n;
		@(posedge pclk);
		wen <= 1'b1;
		for (k = 0; k < 40 && empty_flag !== 1'b0; k++) @(negedge pclk);
		for (n = 0; n < 5000 && full_flag !== 1'b1; n++) @(negedge pclk);
		if (k == 40 || n == 5000) begin
			n_errors++;
			summarize();
		end
		chk(n, depth);
		repeat (30) @(posedge pclk);
		wen <= 1'b0;
	endtask : capture

	// Mode bit 0 dual port, bit 1 pattern
	task automatic readout(input int steps, input logic [1:0] mode);
		int s, k;
		@(posedge pclk);
		go <= 1'b1;
		for (s = 0; s < steps; s++) begin
			for (k = 0; k < 100 && data_ready_strobe === last; k++) @(negedge pclk);
			if (k == 100) begin
				n_errors++;
				summarize();
			end
			last = data_ready_strobe;
			if (s == 0) chk(full_flag, 0);
			chk(port_b_oe_n, !mode[0]);
			if (mode[1]) begin
				chk(port_a_bus, PATTERN_SEQ[mode[0] ? (2 * s + 1) % 8 : s % 8]);
				if (mode[0]) chk(port_b_bus, PATTERN_SEQ[(2 * s) % 8]);
				if (s < steps - 1) chk(out_of_range, 1);
			end else begin
				if (s == 0) chk(out_of_range, 1);
				else chk(mode[0] ? port_b_bus : port_a_bus, 8'(prev + 8'h01));
				if (mode[0]) chk(port_a_bus, 8'(port_b_bus + 8'h01));
			end
			prev = port_a_bus;
		end
		chk(empty_flag, 1);
		chk(out_of_range, 0);
		repeat (40) @(posedge pclk);
		go <= 1'b0;
		chk(data_ready_strobe, last);
	endtask : readout

	initial begin
		{psel, penable, pwrite, paddr, pwdata, sample_data, sor} = '0;
		{wen, go, abuse, buffer_reset, last, n_errors, checks_done} = '0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk({full_flag, empty_flag}, 2'b01);
		apb(1'b0, CTRL_ADDR, 32'h0);
		chk(rd, 32'h0000e7ff);
		apb(1'b0, 12'h100, 32'h0);
		chk(err, 1);
		// Depth 512 with stop on full in every port and source mix,
		// then depth 1024 with the write pointer left to wrap
		for (m = 0; m < 5; m++) begin
			apb(1'b1, CTRL_ADDR, {16'h0, 1'b0, m[2], !m[2], m[0], m[1], 11'h7ff});
			capture(m[2] ? 1024 : 512);
			readout(m[2] ? 1024 : (m[0] ? 256 : 512), m[1:0]);
		end
		// Both enables at once lock the buffer until a buffer reset
		capture(1024);
		@(posedge pclk);
		{wen, go, abuse} <= 3'h7;
		repeat (20) @(posedge pclk);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rd[5], 1);
		chk(data_ready_strobe, last);
		{wen, go, abuse, buffer_reset} <= 4'h1;
		repeat (10) @(posedge pclk);
		buffer_reset <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rd & 32'h3b, 32'h1);
		summarize();
	end
endmodule : tb_top
